// ---- verilog/ccg_pkg.sv ----
// Constants, register map and state encoding of the CPU clock generator
package ccg_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          CCG_ADDR_W      = 8;
	localparam logic [7:0]  CCG_OFF_SEL     = 8'h00;
	localparam logic [7:0]  CCG_OFF_SET     = 8'h04;
	localparam logic [7:0]  CCG_OFF_CLR     = 8'h08;
	localparam logic [7:0]  CCG_OFF_STATUS  = 8'h0C;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int          CCG_DIV_LSB     = 0;
	localparam int          CCG_DIV_W       = 3;
	localparam logic [7:0]  CCG_SEL_RST     = 8'h04;
	localparam logic [2:0]  CCG_DIV_1       = 3'h0;
	localparam logic [2:0]  CCG_DIV_2       = 3'h1;
	localparam logic [2:0]  CCG_DIV_4       = 3'h2;
	localparam logic [2:0]  CCG_DIV_8       = 3'h3;
	localparam logic [2:0]  CCG_DIV_16      = 3'h4;
	localparam int          CCG_ST_OSC_BIT  = 0;
	localparam int          CCG_ST_CPU_BIT  = 1;
	localparam int          CCG_ST_HALT_BIT = 2;
	localparam int          CCG_ST_STOP_BIT = 3;
	localparam int          CCG_ST_DIV_LSB  = 4;

	// ----------------------------------------------------------------
	// AXI responses
	// ----------------------------------------------------------------
	localparam logic [1:0]  CCG_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  CCG_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Timing: stabilisation wait in oscillator periods, prescaler span
	// ----------------------------------------------------------------
	localparam int          CCG_STAB_EXP    = 17;
	localparam int          CCG_STAB_PERIODS = 2 ** CCG_STAB_EXP;
	localparam int          CCG_PRE_W       = 4;
	localparam logic [3:0]  CCG_PRE_LAST    = 4'hF;

	// ----------------------------------------------------------------
	// Operating states
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CCG_ST_WAIT = 2'b00,
		CCG_ST_RUN  = 2'b01,
		CCG_ST_HALT = 2'b10,
		CCG_ST_STOP = 2'b11
	} ccg_state_t;

	// Word address match
	function automatic logic ccg_hit(input logic [7:0] addr, input logic [7:0] off);
		ccg_hit = (addr[7:2] == off[7:2]);
	endfunction

	// Divide code to prescaler mask; reserved codes give the divide-by-16 mask
	function automatic logic [3:0] ccg_mask(input logic [2:0] code);
		case (code)
			CCG_DIV_1:  ccg_mask = 4'h0;
			CCG_DIV_2:  ccg_mask = 4'h1;
			CCG_DIV_4:  ccg_mask = 4'h3;
			CCG_DIV_8:  ccg_mask = 4'h7;
			CCG_DIV_16: ccg_mask = 4'hF;
			default:    ccg_mask = 4'hF;
		endcase
	endfunction

endpackage

// ---- verilog/ccg_prescaler.sv ----
// Free-running divider of the oscillator clock, held at zero while stopped
`timescale 1ns/1ns
module ccg_prescaler
#(
	parameter int W = 4
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         run_i,
	output logic [W-1:0]      cnt_o
);

	typedef struct packed
	{
		logic [W-1:0] cnt;
	} ccg_pre_t;

	ccg_pre_t s_reg;
	ccg_pre_t s_next;

	// ----------------------------------------------------------------
	// Count
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		if (run_i)
			s_next.cnt = s_reg.cnt + W'(1);
		else
			s_next.cnt = '0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign cnt_o = s_reg.cnt;

endmodule

// ---- verilog/ccg_stab_timer.sv ----
// Oscillation stabilisation timer, runs from reset and from each restart
`timescale 1ns/1ns
module ccg_stab_timer
#(
	parameter int CYCLES = 131072
)
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	output logic      done_o
);

	localparam int W = $clog2(CYCLES + 1);

	typedef struct packed
	{
		logic [W-1:0] cnt;
		logic         done;
	} ccg_stab_t;

	ccg_stab_t s_reg;
	ccg_stab_t s_next;

	// ----------------------------------------------------------------
	// Count up to the wait length
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		if (start_i)
		begin
			s_next.cnt  = '0;
			s_next.done = 1'b0;
		end
		else if (!s_reg.done)
		begin
			s_next.cnt = s_reg.cnt + W'(1);
			if (s_reg.cnt == W'(CYCLES - 1))
				s_next.done = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign done_o = s_reg.done;

endmodule

// ---- verilog/ccg_clock_gen.sv ----
// CPU clock generator: divide select, standby control, AXI4-Lite registers
//
// Overview of operation
// - Supply CPU and peripheral clocks; stop oscillation on STOP standby.
// - Reset loads the clock select register with 04h.
// - Select register takes single-bit and whole-byte writes.
// - Shortest instruction spans two CPU clock periods.
// - CPU clock is the oscillator clock divided by 1, 2, 4, 8 or 16.
// - After reset the CPU clock is the slowest, oscillator clock over 16.
// - Oscillation stays stopped while reset is held low.
// - Two standby modes: STOP halts oscillator, HALT stops execution.
// - Peripheral clocks divide the system clock and stop with it.
// - Divide field sits in bits 0 to 2 of the select register.
// - Old clock may persist briefly after a select change, bounded. Here a reserved divide code keeps the old rate until a valid code is written.
// - After reset, wait 2^17 oscillator periods before CPU runs.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module ccg_clock_gen
	import ccg_pkg::*;
#(
	parameter int STAB_CYCLES = ccg_pkg::CCG_STAB_PERIODS
)
(
	input  wire logic                          MCLK_I,
	input  wire logic                          RSTN_I,
	input  wire logic                          STOP_REQ_I,
	input  wire logic                          HALT_REQ_I,
	input  wire logic                          WAKE_I,
	output logic                               OSC_RUN_O,
	output logic                               CPU_RUN_O,
	output logic                               HALTED_O,
	output logic                               RES_INV_PIN_O,
	output logic                               CPU_CLK_EN_O,
	output logic                               INSTR_SLOT_O,
	output logic [3:0]                         PERIPH_TICK_O,
	input  wire logic [ccg_pkg::CCG_ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire logic                          S_AXI_AWVALID_I,
	output logic                               S_AXI_AWREADY_O,
	input  wire logic [31:0]                   S_AXI_WDATA_I,
	input  wire logic [3:0]                    S_AXI_WSTRB_I,
	input  wire logic                          S_AXI_WVALID_I,
	output logic                               S_AXI_WREADY_O,
	output logic [1:0]                         S_AXI_BRESP_O,
	output logic                               S_AXI_BVALID_O,
	input  wire logic                          S_AXI_BREADY_I,
	input  wire logic [ccg_pkg::CCG_ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire logic                          S_AXI_ARVALID_I,
	output logic                               S_AXI_ARREADY_O,
	output logic [31:0]                        S_AXI_RDATA_O,
	output logic [1:0]                         S_AXI_RRESP_O,
	output logic                               S_AXI_RVALID_O,
	input  wire logic                          S_AXI_RREADY_I
);

	import ccg_pkg::*;

	typedef struct packed
	{
		ccg_state_t             st;
		logic [7:0]             sel;
		logic [2:0]             sel_eff;
		logic                   osc_run;
		logic                   cpu_run;
		logic                   halted;
		logic                   inv_pin;
		logic                   cpu_en;
		logic                   instr_ph;
		logic                   instr_slot;
		logic [3:0]             ptick;
		logic                   aw_held;
		logic [CCG_ADDR_W-1:0]  aw_addr;
		logic                   w_held;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} ccg_top_t;

	ccg_top_t               r_reg;
	ccg_top_t               r_next;
	logic [CCG_PRE_W-1:0]   pre_cnt;
	logic                   stab_done;
	logic                   stab_start;
	logic [3:0]             cur_mask;
	logic [7:0]             wbyte;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	ccg_prescaler #(.W(CCG_PRE_W)) u_pre
	(
		.clk_i   (MCLK_I),
		.rst_n_i (RSTN_I),
		.run_i   (r_reg.osc_run),
		.cnt_o   (pre_cnt)
	);

	ccg_stab_timer #(.CYCLES(STAB_CYCLES)) u_stab
	(
		.clk_i   (MCLK_I),
		.rst_n_i (RSTN_I),
		.start_i (stab_start),
		.done_o  (stab_done)
	);

	// Wake from STOP restarts the stabilisation wait
	assign stab_start = (r_reg.st == CCG_ST_STOP) && WAKE_I;
	assign cur_mask   = ccg_mask(r_reg.sel_eff);
	assign wbyte      = r_reg.wdata[7:0];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		r_next = r_reg;

		// ------------------------------------------------------------
		// Standby and start-up sequencing
		// ------------------------------------------------------------
		case (r_reg.st)
			CCG_ST_WAIT:
			begin
				if (stab_done)
					r_next.st = CCG_ST_RUN;
			end
			CCG_ST_RUN:
			begin
				if (STOP_REQ_I)
					r_next.st = CCG_ST_STOP;
				else if (HALT_REQ_I)
					r_next.st = CCG_ST_HALT;
			end
			CCG_ST_HALT:
			begin
				if (WAKE_I)
					r_next.st = CCG_ST_RUN;
			end
			CCG_ST_STOP:
			begin
				if (WAKE_I)
					r_next.st = CCG_ST_WAIT;
			end
			default:
			begin
				r_next.st = CCG_ST_WAIT;
			end
		endcase

		// ------------------------------------------------------------
		// Standby outputs
		// ------------------------------------------------------------
		r_next.osc_run = (r_next.st != CCG_ST_STOP);
		r_next.inv_pin = (r_next.st == CCG_ST_STOP);
		r_next.cpu_run = (r_next.st == CCG_ST_RUN);
		r_next.halted  = (r_next.st == CCG_ST_HALT);

		// ------------------------------------------------------------
		// Rate change only at prescaler wrap, common edge of all rates
		// ------------------------------------------------------------
		if (pre_cnt == CCG_PRE_LAST && r_reg.sel[2:0] <= CCG_DIV_16)
			r_next.sel_eff = r_reg.sel[CCG_DIV_LSB +: CCG_DIV_W];

		// ------------------------------------------------------------
		// CPU clock enable from divided oscillator
		// ------------------------------------------------------------
		r_next.cpu_en = r_reg.osc_run && ((pre_cnt & cur_mask) == cur_mask)
			&& (r_next.st == CCG_ST_RUN);
		if (r_reg.cpu_en)
			r_next.instr_ph = ~r_reg.instr_ph;
		r_next.instr_slot = r_reg.cpu_en && r_reg.instr_ph;

		// ------------------------------------------------------------
		// Peripheral ticks at oscillator over 2, 4, 8 and 16
		// ------------------------------------------------------------
		r_next.ptick[0] = r_reg.osc_run && pre_cnt[0];
		r_next.ptick[1] = r_reg.osc_run && (&pre_cnt[1:0]);
		r_next.ptick[2] = r_reg.osc_run && (&pre_cnt[2:0]);
		r_next.ptick[3] = r_reg.osc_run && (&pre_cnt[3:0]);

		// ------------------------------------------------------------
		// AXI4-Lite write
		// ------------------------------------------------------------
		if (S_AXI_AWVALID_I && r_reg.awready)
		begin
			r_next.aw_held = 1'b1;
			r_next.aw_addr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && r_reg.wready)
		begin
			r_next.w_held = 1'b1;
			r_next.wdata  = S_AXI_WDATA_I;
			r_next.wstrb  = S_AXI_WSTRB_I;
		end

		// ------------------------------------------------------------
		// Response release
		// ------------------------------------------------------------
		if (S_AXI_BREADY_I && r_reg.bvalid)
			r_next.bvalid = 1'b0;

		// ------------------------------------------------------------
		// Register update once address and data are both held
		// ------------------------------------------------------------
		if (r_reg.aw_held && r_reg.w_held && !r_reg.bvalid)
		begin
			r_next.aw_held = 1'b0;
			r_next.w_held  = 1'b0;
			r_next.bvalid  = 1'b1;
			r_next.bresp   = CCG_RESP_OKAY;
			if (ccg_hit(r_reg.aw_addr, CCG_OFF_SEL))
			begin
				if (r_reg.wstrb[0])
					r_next.sel = wbyte;
			end
			else if (ccg_hit(r_reg.aw_addr, CCG_OFF_SET))
			begin
				if (r_reg.wstrb[0])
					r_next.sel = r_reg.sel | wbyte;
			end
			else if (ccg_hit(r_reg.aw_addr, CCG_OFF_CLR))
			begin
				if (r_reg.wstrb[0])
					r_next.sel = r_reg.sel & ~wbyte;
			end
			else if (!ccg_hit(r_reg.aw_addr, CCG_OFF_STATUS))
				r_next.bresp = CCG_RESP_SLVERR;
		end

		// ------------------------------------------------------------
		// Ready flags, low while a write is pending
		// ------------------------------------------------------------
		r_next.awready = !r_next.aw_held && !r_next.bvalid;
		r_next.wready  = !r_next.w_held && !r_next.bvalid;

		// ------------------------------------------------------------
		// AXI4-Lite read
		// ------------------------------------------------------------
		if (S_AXI_RREADY_I && r_reg.rvalid)
			r_next.rvalid = 1'b0;

		// ------------------------------------------------------------
		// Address decode and read data
		// ------------------------------------------------------------
		if (S_AXI_ARVALID_I && r_reg.arready)
		begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = CCG_RESP_OKAY;
			r_next.rdata  = 32'h0000_0000;
			if (ccg_hit(S_AXI_ARADDR_I, CCG_OFF_SEL) || ccg_hit(S_AXI_ARADDR_I, CCG_OFF_SET)
				|| ccg_hit(S_AXI_ARADDR_I, CCG_OFF_CLR))
				r_next.rdata[7:0] = r_reg.sel;
			else if (ccg_hit(S_AXI_ARADDR_I, CCG_OFF_STATUS))
			begin
				r_next.rdata[CCG_ST_OSC_BIT]  = r_reg.osc_run;
				r_next.rdata[CCG_ST_CPU_BIT]  = r_reg.cpu_run;
				r_next.rdata[CCG_ST_HALT_BIT] = r_reg.halted;
				r_next.rdata[CCG_ST_STOP_BIT] = r_reg.inv_pin;
				r_next.rdata[CCG_ST_DIV_LSB +: CCG_DIV_W] = r_reg.sel_eff;
			end
			else
				r_next.rresp = CCG_RESP_SLVERR;
		end
		r_next.arready = !r_next.rvalid;
	end

	// ----------------------------------------------------------------
	// State register; reset keeps oscillator off and selects fx/16
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			r_reg <= '{st: CCG_ST_WAIT, sel: CCG_SEL_RST, sel_eff: CCG_DIV_16, default: '0};
		else
			r_reg <= r_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign OSC_RUN_O       = r_reg.osc_run;
	assign CPU_RUN_O       = r_reg.cpu_run;
	assign HALTED_O        = r_reg.halted;
	assign RES_INV_PIN_O   = r_reg.inv_pin;
	assign CPU_CLK_EN_O    = r_reg.cpu_en;
	assign INSTR_SLOT_O    = r_reg.instr_slot;
	assign PERIPH_TICK_O   = r_reg.ptick;
	assign S_AXI_AWREADY_O = r_reg.awready;
	assign S_AXI_WREADY_O  = r_reg.wready;
	assign S_AXI_BRESP_O   = r_reg.bresp;
	assign S_AXI_BVALID_O  = r_reg.bvalid;
	assign S_AXI_ARREADY_O = r_reg.arready;
	assign S_AXI_RDATA_O   = r_reg.rdata;
	assign S_AXI_RRESP_O   = r_reg.rresp;
	assign S_AXI_RVALID_O  = r_reg.rvalid;

endmodule

// ---- verification/ccg_clock_gen_sva.sv ----
// Concurrent checks on the clock generator ports
`timescale 1ns/1ns
module ccg_sva
#(
	parameter int STAB_CYCLES = 16
)
(
	input wire logic        MCLK_I,
	input wire logic        RSTN_I,
	input wire logic        STOP_REQ_I,
	input wire logic        HALT_REQ_I,
	input wire logic        OSC_RUN_O,
	input wire logic        CPU_RUN_O,
	input wire logic        HALTED_O,
	input wire logic        RES_INV_PIN_O,
	input wire logic        CPU_CLK_EN_O,
	input wire logic        INSTR_SLOT_O,
	input wire logic [3:0]  PERIPH_TICK_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic        S_AXI_RVALID_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic        S_AXI_RREADY_I
);
	// ------------------------------------------------------------
	// Wait counter and checks
	// ------------------------------------------------------------
	logic [31:0] cnt_reg;
	always_ff @(posedge MCLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			cnt_reg <= 32'h0;
		else if (!OSC_RUN_O || HALTED_O)
			cnt_reg <= 32'h0;
		else if (!CPU_RUN_O)
			cnt_reg <= cnt_reg + 32'h1;
	end
	default clocking dck @(posedge MCLK_I);
	endclocking
	default disable iff (!RSTN_I);
	a_stab_wait: assert property (
		$rose(CPU_RUN_O) && !$past(HALTED_O) |-> cnt_reg >= STAB_CYCLES - 1 && cnt_reg <= STAB_CYCLES + 1)
		else $error("CPU start off the wait count");
	a_stop_osc: assert property (
		STOP_REQ_I && CPU_RUN_O && !$past(HALT_REQ_I) && !$past(STOP_REQ_I) |-> ##[1:3] !OSC_RUN_O && RES_INV_PIN_O)
		else $error("STOP did not halt oscillation");
	a_stop_pin: assert property (RES_INV_PIN_O |-> !OSC_RUN_O && !CPU_RUN_O)
		else $error("Inverted pin high while running");
	a_tick_stop: assert property (!OSC_RUN_O [*3] |-> PERIPH_TICK_O == 4'h0)
		else $error("Peripheral tick while stopped");
	a_tick_cad: assert property (
		PERIPH_TICK_O[1] |=> !PERIPH_TICK_O[1] [*3] ##1 (PERIPH_TICK_O[1] || !OSC_RUN_O))
		else $error("Peripheral tick spacing wrong");
	a_slot_gap: assert property (INSTR_SLOT_O |=> !INSTR_SLOT_O)
		else $error("Instruction slots back to back");
	a_halt_quiet: assert property (
		HALTED_O [*2] |-> OSC_RUN_O && !CPU_CLK_EN_O && !INSTR_SLOT_O)
		else $error("Activity during halt");
	a_bresp_hold: assert property (
		S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("Write response dropped");
	a_rdata_hold: assert property (
		S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("Read data dropped");
endmodule
bind ccg_clock_gen ccg_sva #(.STAB_CYCLES(STAB_CYCLES)) sva_u (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
	.STOP_REQ_I(STOP_REQ_I), .HALT_REQ_I(HALT_REQ_I), .OSC_RUN_O(OSC_RUN_O), .CPU_RUN_O(CPU_RUN_O),
	.HALTED_O(HALTED_O), .RES_INV_PIN_O(RES_INV_PIN_O), .CPU_CLK_EN_O(CPU_CLK_EN_O),
	.INSTR_SLOT_O(INSTR_SLOT_O), .PERIPH_TICK_O(PERIPH_TICK_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_RVALID_O(S_AXI_RVALID_O),
	.S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RREADY_I(S_AXI_RREADY_I));

// ---- verification/tb.sv ----
// Self-checking bench for the CPU clock generator
`timescale 1ns/1ns
module tb;
	import ccg_pkg::*;
	localparam int STB = 16;
	logic        clk = 1'b0, rstn = 1'b0, stp = 1'b0, hlt = 1'b0, wk = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [3:0]  ws = 4'h0;
	logic        osc, run, hld, pin, cen, slot, awr, wrd, bv, arr, rv;
	logic [3:0]  tick;
	logic [1:0]  br, rr;
	logic [31:0] rdat;
	int          bad_count = 0, n_compared = 0, cyc = 0;
	always #5 clk = ~clk;
	ccg_clock_gen #(.STAB_CYCLES(STB)) dut_u (.MCLK_I(clk), .RSTN_I(rstn), .STOP_REQ_I(stp), .HALT_REQ_I(hlt),
		.WAKE_I(wk), .OSC_RUN_O(osc), .CPU_RUN_O(run), .HALTED_O(hld), .RES_INV_PIN_O(pin), .CPU_CLK_EN_O(cen),
		.INSTR_SLOT_O(slot), .PERIPH_TICK_O(tick), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
		.S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			bad_count++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chb(input logic g, input logic e);
		chk(32'(g), 32'(e));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		@(posedge clk);
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		fork
			begin
				@(posedge clk iff awr);
				awv <= 1'b0;
			end
			begin
				@(posedge clk iff wrd);
				wv <= 1'b0;
			end
		join
		@(posedge clk iff bv);
		bre <= 1'b0;
		chk(32'(br), 32'(r));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		@(posedge clk iff arr);
		arv <= 1'b0;
		@(posedge clk iff rv);
		rre <= 1'b0;
		chk(rdat, e);
		chk(32'(rr), 32'(r));
	endtask
	// Cycles from one CPU clock pulse (or slot) to the next
	task automatic per(input logic s, input logic [7:0] e);
		logic [7:0] n;
		n = 8'h00;
		@(negedge clk iff (s ? slot : cen));
		do
		begin
			@(negedge clk);
			n++;
		end
		while (!(s ? slot : cen) && n < 8'h40);
		chk(32'(n), 32'(e));
	endtask
	task automatic quiet(output logic [7:0] nc, output logic [7:0] np);
		nc = 8'h00;
		np = 8'h00;
		repeat (32)
		begin
			@(negedge clk);
			nc = nc + 8'(cen);
			// Weighted tick sum: each running bit adds 16 per 32 cycles
			np = np + 8'(tick);
		end
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_boot;
		chb(osc, 1'b0);
		chb(run, 1'b0);
		@(posedge clk);
		rstn <= 1'b1;
		repeat (STB - 1) @(negedge clk);
		chb(run, 1'b0);
		@(negedge clk iff run);
		rd(CCG_OFF_SEL, 32'h04, CCG_RESP_OKAY);
		rd(CCG_OFF_STATUS, 32'h43, CCG_RESP_OKAY);
		per(1'b0, 8'h10);
	endtask
	task automatic t_div;
		for (int k = 0; k < 5; k++)
		begin
			wr(CCG_OFF_SEL, 32'(k), 4'h1, CCG_RESP_OKAY);
			repeat (40) @(negedge clk);
			per(1'b0, 8'h01 << k);
			per(1'b1, 8'h02 << k);
		end
		wr(CCG_OFF_SEL, 32'h05, 4'h1, CCG_RESP_OKAY);
		rd(CCG_OFF_SEL, 32'h05, CCG_RESP_OKAY);
		repeat (40) @(negedge clk);
		per(1'b0, 8'h10);
	endtask
	task automatic t_bits;
		wr(CCG_OFF_CLR, 32'h05, 4'h1, CCG_RESP_OKAY);
		wr(CCG_OFF_SET, 32'h02, 4'h1, CCG_RESP_OKAY);
		wr(CCG_OFF_SEL, 32'h01, 4'h0, CCG_RESP_OKAY);
		wr(CCG_OFF_STATUS, 32'h0, 4'h1, CCG_RESP_OKAY);
		wr(8'h10, 32'h01, 4'h1, CCG_RESP_SLVERR);
		rd(8'h10, 32'h0, CCG_RESP_SLVERR);
		rd(CCG_OFF_SEL, 32'h02, CCG_RESP_OKAY);
		repeat (40) @(negedge clk);
		per(1'b0, 8'h04);
	endtask
	task automatic t_halt;
		logic [7:0] nc, np;
		@(posedge clk);
		hlt <= 1'b1;
		@(posedge clk);
		hlt <= 1'b0;
		repeat (3) @(negedge clk);
		quiet(nc, np);
		chb(hld, 1'b1);
		chb(osc, 1'b1);
		chk(32'(nc), 32'h0);
		chk(32'(np), 32'h40);
		@(posedge clk);
		wk <= 1'b1;
		@(posedge clk);
		wk <= 1'b0;
		repeat (3) @(negedge clk);
		chb(run, 1'b1);
		chb(hld, 1'b0);
	endtask
	task automatic t_stop;
		logic [7:0] nc, np;
		@(posedge clk);
		stp <= 1'b1;
		@(posedge clk);
		stp <= 1'b0;
		repeat (3) @(negedge clk);
		quiet(nc, np);
		chb(osc, 1'b0);
		chb(pin, 1'b1);
		chk(32'(nc), 32'h0);
		chk(32'(np), 32'h0);
		@(posedge clk);
		wk <= 1'b1;
		@(posedge clk);
		wk <= 1'b0;
		repeat (3) @(negedge clk);
		chb(pin, 1'b0);
		chb(osc, 1'b1);
		@(negedge clk iff run);
		per(1'b0, 8'h04);
	endtask
	task automatic t_rst2;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(negedge clk);
		chb(osc, 1'b0);
		chb(cen, 1'b0);
		@(posedge clk);
		rstn <= 1'b1;
		@(negedge clk iff run);
		rd(CCG_OFF_SEL, 32'h04, CCG_RESP_OKAY);
		per(1'b0, 8'h10);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		t_boot;
		t_div;
		t_bits;
		t_halt;
		t_stop;
		t_rst2;
		report_and_stop;
	end
endmodule
